// >>> logic/cpg_clock_generator.sv
// Purpose: clock generator with frequency control, watchdog and standby gating
// Assumes: reference clock stands in for the multiplied PLL output
// Notes: divided clocks are modelled as enables shaped into clean clocks
`timescale 1ns/1ns
module cpg_clock_generator #(
    parameter int STAB_CYC = cpg_pkg::CPG_STAB_CYC,
    parameter int WDT_PRE_W = cpg_pkg::CPG_WDT_PRE_W
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // mode pins
    input wire logic i_mode_select_bit0,
    input wire logic i_mode_select_bit1,
    input wire logic i_mode_select_bit2,
    input wire logic i_crystal_select,
    input wire logic i_wide_variant,
    // register port
    input wire logic [cpg_pkg::CPG_AW-1:0] i_addr,
    input wire logic [cpg_pkg::CPG_DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [cpg_pkg::CPG_DW-1:0] o_rdata,
    // wake-up request from power-down
    input wire logic i_wake,
    // generated clocks
    output logic o_core_clk,
    output logic o_bus_clk,
    output logic o_periph_clk,
    output logic o_bus_clock_out,
    output logic o_bus_clock_out_oen,
    output logic o_clock_enable,
    output logic [cpg_pkg::CPG_NMOD-1:0] o_module_clk_en,
    output logic [2:0] o_mult,
    output logic o_half_div_on,
    // resets and interrupt
    output logic o_poweron_rst_req,
    output logic o_manual_rst_req,
    output logic o_irq
);
    import cpg_pkg::*;

    typedef struct packed {
        logic [15:0] frq;
        logic [15:0] wdt;
        logic [15:0] stb;
        logic [CPG_NIRQ-1:0] stat;
        logic [CPG_NIRQ-1:0] mask;
        logic [15:0] rdata;
        logic mode_loaded;
        logic [2:0] mode;
        cpg_state_e state;
        logic [31:0] stab_cnt;
        logic [WDT_PRE_W-1:0] pre;
        logic [7:0] wcnt;
        logic half_div;
        logic [CPG_NMOD-1:0] mod_en;
        logic cke;
        logic pon;
        logic man;
        logic irq;
        logic clk_oen;
    } cpg_top_s;

    cpg_top_s st_reg;
    cpg_top_s st_next;
    logic core_c, bus_c, per_c;
    logic core_e, bus_e, per_e;
    logic run_clk;
    logic frq_hit, wdt_hit, stb_hit, stat_hit, mask_hit, state_hit;
    logic [2:0] mode_pins;
    logic wdt_tick;
    logic [3:0] wdt_tap;
    logic [WDT_PRE_W-1:0] wdt_low;
    logic [CPG_NIRQ-1:0] ev;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign frq_hit = (i_addr == CPG_FRQ_ADDR) || (i_addr == CPG_FRQ_ADDR_ALT);
    assign wdt_hit = i_addr == CPG_WDT_ADDR;
    assign stb_hit = i_addr == CPG_STB_ADDR;
    assign stat_hit = i_addr == CPG_IRQ_STAT_ADDR;
    assign mask_hit = i_addr == CPG_IRQ_MASK_ADDR;
    assign state_hit = i_addr == CPG_STATE_ADDR;
    assign mode_pins = {i_mode_select_bit2, i_mode_select_bit1, i_mode_select_bit0};
    assign run_clk = st_reg.state == CPG_RUN;

    // ----------------------------------------------------------------
    // dividers
    // ----------------------------------------------------------------
    cpg_clk_div u_core (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_half(cpg_ratio(st_reg.frq[CPG_F_IFC_LO +: 3])),
        .i_run(run_clk),
        .o_clk(core_c),
        .o_edge(core_e)
    );
    cpg_clk_div u_bus (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_half(cpg_ratio(st_reg.frq[CPG_F_BFC_LO +: 3])),
        .i_run(run_clk),
        .o_clk(bus_c),
        .o_edge(bus_e)
    );
    cpg_clk_div u_per (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_half(cpg_ratio(st_reg.frq[CPG_F_PFC_LO +: 3])),
        .i_run(run_clk),
        .o_clk(per_c),
        .o_edge(per_e)
    );

    // watchdog prescale tap selected from eight: one tick as the tap bit rises, all bits below clear
    assign wdt_tap = {1'b0, st_reg.wdt[CPG_W_CKS_LO +: 3]} + 4'h4;
    assign wdt_low = WDT_PRE_W'((32'h1 << wdt_tap) - 32'h1);
    assign wdt_tick = st_reg.pre[wdt_tap] && ((st_reg.pre & wdt_low) == '0);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        ev = '0;
        st_next.pre = st_reg.pre + 1'b1;
        st_next.pon = 1'b0;
        st_next.man = 1'b0;
        // power-on load from the mode pins after release
        if (!st_reg.mode_loaded) begin
            st_next.mode_loaded = 1'b1;
            st_next.mode = mode_pins;
            st_next.frq = cpg_mode_init(mode_pins);
        end
        // register reads answer one cycle later
        st_next.rdata = 16'h0000;
        if (i_rd) begin
            if (frq_hit) begin
                st_next.rdata = st_reg.frq;
            end else if (wdt_hit) begin
                st_next.rdata = {st_reg.wcnt, st_reg.wdt[7:0]};
            end else if (stb_hit) begin
                st_next.rdata = st_reg.stb;
            end else if (stat_hit) begin
                st_next.rdata = {13'h0000, st_reg.stat};
            end else if (mask_hit) begin
                st_next.rdata = {13'h0000, st_reg.mask};
            end else if (state_hit) begin
                st_next.rdata = {11'h000, st_reg.mode, st_reg.state};
            end
        end
        // register writes
        if (i_wr && st_reg.mode_loaded) begin
            if (frq_hit) begin
                st_next.frq = i_wdata & CPG_FRQ_WMASK;
            end else if (wdt_hit) begin
                st_next.wdt = i_wdata & CPG_WDT_WMASK;
                st_next.wcnt = 8'h00;
            end else if (stb_hit) begin
                st_next.stb = i_wdata & CPG_STB_WMASK;
            end else if (mask_hit) begin
                st_next.mask = i_wdata[CPG_NIRQ-1:0];
            end
        end
        // power-down and stabilisation
        case (st_reg.state)
            CPG_RUN: begin
                if (st_reg.stb[CPG_S_SLEEP] || st_reg.stb[CPG_S_STBY]) begin
                    st_next.state = CPG_HALTED;
                end
            end
            CPG_HALTED: begin
                if (i_wake) begin
                    st_next.stb[CPG_S_SLEEP] = 1'b0;
                    st_next.stb[CPG_S_STBY] = 1'b0;
                    st_next.state = st_reg.stb[CPG_S_STBY] ? CPG_STABILISE : CPG_RUN;
                    st_next.stab_cnt = '0;
                end
            end
            CPG_STABILISE: begin
                if (st_reg.stab_cnt >= 32'(STAB_CYC - 1)) begin
                    st_next.state = CPG_RUN;
                    ev[CPG_I_STAB] = 1'b1;
                end else begin
                    st_next.stab_cnt = st_reg.stab_cnt + 32'h1;
                end
            end
            default: st_next.state = CPG_RUN;
        endcase
        // a frequency change restarts the stabilisation count whatever the state did
        if (i_wr && frq_hit && st_reg.mode_loaded) begin
            st_next.state = CPG_STABILISE;
            st_next.stab_cnt = '0;
        end
        // watchdog counter
        if (st_reg.wdt[CPG_W_EN] && wdt_tick) begin
            st_next.wcnt = st_reg.wcnt + 8'h01;
            if (st_reg.wcnt == 8'hff) begin
                if (st_reg.wdt[CPG_W_ITV]) begin
                    ev[CPG_I_ITV] = 1'b1;
                end else begin
                    ev[CPG_I_RST] = 1'b1;
                    st_next.pon = ~st_reg.wdt[CPG_W_MRST];
                    st_next.man = st_reg.wdt[CPG_W_MRST];
                end
            end
        end
        // sticky status, set wins over write-one clear
        if (i_wr && stat_hit) begin
            st_next.stat = st_reg.stat & ~i_wdata[CPG_NIRQ-1:0];
        end
        st_next.stat = st_next.stat | ev;
        st_next.irq = |(st_next.stat & st_next.mask);
        // halving without first multiplier, except on the wide variant
        st_next.half_div = ~st_next.frq[CPG_F_PLL1] && ~i_wide_variant;
        // module gates and clock enable
        st_next.mod_en = ~st_next.stb[CPG_S_MSTP_LO +: CPG_NMOD];
        st_next.cke = (st_next.state == CPG_RUN) && ~st_next.stb[CPG_S_SELF];
        st_next.clk_oen = ~st_next.frq[CPG_F_CKOEN];
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '{frq: 16'h0000, wdt: 16'h0000, stb: 16'h0000, stat: '0, mask: '0,
                rdata: 16'h0000, mode_loaded: 1'b0, mode: 3'h0, state: CPG_RUN,
                stab_cnt: 32'h0, pre: '0, wcnt: 8'h00, half_div: 1'b0, mod_en: '1,
                cke: 1'b1, pon: 1'b0, man: 1'b0, irq: 1'b0, clk_oen: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_core_clk <= 1'b0;
            o_bus_clk <= 1'b0;
            o_periph_clk <= 1'b0;
            o_bus_clock_out <= 1'b0;
            o_mult <= 3'h6;
        end else begin
            o_core_clk <= core_c;
            o_bus_clk <= bus_c;
            o_periph_clk <= per_c;
            // pin follows bus clock when second multiplier runs and clock fix is clear, else held high
            o_bus_clock_out <= (st_reg.frq[CPG_F_PLL2] && !st_reg.stb[CPG_S_CKFIX]) ? bus_c : 1'b1;
            // first multiplier factor
            o_mult <= !st_reg.frq[CPG_F_PLL1] ? 3'h1 :
                (i_wide_variant && st_reg.mode[0]) ? 3'(CPG_MULT_HI / 2) : 3'(CPG_MULT_LO);
        end
    end

    assign o_rdata = st_reg.rdata;
    assign o_bus_clock_out_oen = st_reg.clk_oen;
    assign o_clock_enable = st_reg.cke;
    assign o_module_clk_en = st_reg.mod_en;
    assign o_half_div_on = st_reg.half_div;
    assign o_poweron_rst_req = st_reg.pon;
    assign o_manual_rst_req = st_reg.man;
    assign o_irq = st_reg.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_cke_halt: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (st_reg.state == CPG_HALTED) |-> !o_clock_enable) else $error("clock enable high while halted");
    chk_halt_clocks: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (st_reg.state == CPG_HALTED) [*3] |-> !core_e) else $error("core clock edge while halted");
    chk_itv_irq: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ev[CPG_I_ITV] |=> st_reg.stat[CPG_I_ITV] && !o_poweron_rst_req) else $error("interval overflow lost");
    chk_wdt_reset: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ev[CPG_I_RST] |=> (o_poweron_rst_req != o_manual_rst_req)) else $error("watchdog reset missing");
    chk_frq_stab: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_wr && frq_hit && st_reg.mode_loaded) |=> st_reg.state == CPG_STABILISE) else $error("no stabilisation");
    chk_mode_load: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $rose(st_reg.mode_loaded) |-> st_reg.frq == cpg_mode_init(st_reg.mode)) else $error("bad initial value");
    chk_half_div: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (st_reg.mode_loaded && !st_reg.frq[CPG_F_PLL1] && !i_wide_variant) |-> o_half_div_on)
        else $error("halving not on");
    chk_fixed_pin: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        st_reg.stb[CPG_S_CKFIX] |=> o_bus_clock_out) else $error("pin not held");
endmodule : cpg_clock_generator

// >>> logic/cpg_pkg.sv
// Purpose: shared constants and types of the clock generator block
// Assumes: 125 MHz reference clock, 16-bit register port
// Notes: frequency control layout and mode table live here
package cpg_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [31:0] CPG_FRQ_ADDR = 32'hffc00000;
    localparam logic [31:0] CPG_FRQ_ADDR_ALT = 32'h1fc00000;
    localparam logic [31:0] CPG_WDT_ADDR = 32'hffc00010;
    localparam logic [31:0] CPG_STB_ADDR = 32'hffc00020;
    localparam logic [31:0] CPG_IRQ_STAT_ADDR = 32'hffc00030;
    localparam logic [31:0] CPG_IRQ_MASK_ADDR = 32'hffc00034;
    localparam logic [31:0] CPG_STATE_ADDR = 32'hffc00038;
    localparam int CPG_AW = 32;
    localparam int CPG_DW = 16;
    // ----------------------------------------------------------------
    // frequency control fields
    // ----------------------------------------------------------------
    localparam int CPG_F_CKOEN = 11;
    localparam int CPG_F_PLL1 = 10;
    localparam int CPG_F_PLL2 = 9;
    localparam int CPG_F_IFC_LO = 6;
    localparam int CPG_F_BFC_LO = 3;
    localparam int CPG_F_PFC_LO = 0;
    localparam logic [15:0] CPG_FRQ_WMASK = 16'h0fff;
    // ----------------------------------------------------------------
    // watchdog control fields
    // ----------------------------------------------------------------
    localparam int CPG_W_EN = 7;
    localparam int CPG_W_ITV = 6;
    localparam int CPG_W_MRST = 5;
    localparam int CPG_W_CKS_LO = 0;
    localparam logic [15:0] CPG_WDT_WMASK = 16'h00e7;
    // ----------------------------------------------------------------
    // standby control fields
    // ----------------------------------------------------------------
    localparam int CPG_S_SLEEP = 15;
    localparam int CPG_S_STBY = 14;
    localparam int CPG_S_SELF = 13;
    localparam int CPG_S_CKFIX = 12;
    localparam int CPG_S_MSTP_LO = 0;
    localparam int CPG_NMOD = 8;
    localparam logic [15:0] CPG_STB_WMASK = 16'hf0ff;
    // ----------------------------------------------------------------
    // interrupt bits
    // ----------------------------------------------------------------
    localparam int CPG_I_ITV = 0;
    localparam int CPG_I_STAB = 1;
    localparam int CPG_I_RST = 2;
    localparam int CPG_NIRQ = 3;
    // ----------------------------------------------------------------
    // clock constants
    // ----------------------------------------------------------------
    localparam int CPG_MULT_LO = 6;
    localparam int CPG_MULT_HI = 12;
    localparam int CPG_NMODES = 6;
    localparam int CPG_STAB_US = 10;
    localparam int CPG_CLK_MHZ = 125;
    localparam int CPG_STAB_CYC = CPG_STAB_US * CPG_CLK_MHZ;
    localparam int CPG_WDT_PRE_W = 12;

    typedef enum logic [1:0] {CPG_RUN, CPG_STABILISE, CPG_HALTED} cpg_state_e;

    // power-on value of the frequency control register for each mode
    function automatic logic [15:0] cpg_mode_init(input logic [2:0] mode);
        case (mode)
            3'h0: cpg_mode_init = 16'h0e1a;
            3'h1: cpg_mode_init = 16'h0e23;
            3'h2: cpg_mode_init = 16'h0e13;
            3'h3: cpg_mode_init = 16'h0e13;
            3'h4: cpg_mode_init = 16'h0e0a;
            3'h5: cpg_mode_init = 16'h0e0a;
            default: cpg_mode_init = 16'h0e1a;
        endcase
    endfunction : cpg_mode_init

    // three-bit ratio code to half-period in reference cycles
    function automatic logic [3:0] cpg_ratio(input logic [2:0] code);
        case (code)
            3'h0: cpg_ratio = 4'h1;
            3'h1: cpg_ratio = 4'h2;
            3'h2: cpg_ratio = 4'h3;
            3'h3: cpg_ratio = 4'h4;
            3'h4: cpg_ratio = 4'h6;
            3'h5: cpg_ratio = 4'h8;
            default: cpg_ratio = 4'h8;
        endcase
    endfunction : cpg_ratio
endpackage : cpg_pkg

// >>> logic/cpg_clk_div.sv
// Purpose: glitch-free divided clock output
// Assumes: new half period is loaded at a completed low phase or while stopped low
// Notes: output finishes its high phase, then stands low while halted
`timescale 1ns/1ns
module cpg_clk_div (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // control
    input wire logic [3:0] i_half,
    input wire logic i_run,
    // output
    output logic o_clk,
    output logic o_edge
);
    import cpg_pkg::*;

    typedef struct packed {
        logic [3:0] cnt;
        logic [3:0] half;
        logic clk;
        logic edge_p;
    } cpg_div_s;

    cpg_div_s st_reg;
    cpg_div_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.edge_p = 1'b0;
        if (i_run || st_reg.clk) begin
            if (st_reg.cnt + 4'h1 >= st_reg.half) begin
                st_next.cnt = 4'h0;
                st_next.clk = ~st_reg.clk;
                st_next.edge_p = ~st_reg.clk;
                // ratio change only at the end of a low phase
                if (!st_reg.clk) begin
                    st_next.half = i_half;
                end
            end else begin
                st_next.cnt = st_reg.cnt + 4'h1;
            end
        end else begin
            st_next.cnt = 4'h0;
            st_next.half = i_half;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '{cnt: 4'h0, half: 4'h1, clk: 1'b0, edge_p: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_clk = st_reg.clk;
    assign o_edge = st_reg.edge_p;

    chk_high_min: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (st_reg.clk && (st_reg.cnt + 4'h1 < st_reg.half)) |=> st_reg.clk) else $error("runt high phase");
endmodule : cpg_clk_div

// >>> verif/cpg_ext_board.sv
// Purpose: board model with the crystal strap and the bus clock pin pull-up
// Assumes: an oscillator feeds the reference clock directly
// Notes: a released bus clock pin reads high through its pull-up
`timescale 1ns/1ns
module cpg_ext_board #(
    parameter logic USE_CRYSTAL = 1'b0
) (
    // bus clock pin from the device
    input wire logic i_bus_clock_out,
    input wire logic i_bus_clock_out_oen,
    // board side
    output logic o_crystal_select,
    output logic o_pin_level
);
    // strap low for an oscillator, high for a crystal
    assign o_crystal_select = USE_CRYSTAL;
    assign o_pin_level = i_bus_clock_out_oen ? 1'b1 : i_bus_clock_out;
endmodule : cpg_ext_board

// >>> verif/cpg_clock_generator_test.sv
// Purpose: self-checking bench of the clock generator
// Assumes: stabilisation count shortened to 8 cycles
// Notes: power-on cases come from a table, the rest are written out
`timescale 1ns/1ns
module cpg_clock_generator_test;
    import cpg_pkg::*;
    localparam int STAB = 8;
    typedef struct packed {logic [2:0] mode; logic wide; logic [15:0] frq;} cpg_row_s;
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [2:0] mode = 3'h0;
    logic wide = 1'b0;
    logic [31:0] i_addr = 32'h0;
    logic [15:0] i_wdata = 16'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_wake = 1'b0;
    logic [15:0] o_rdata;
    logic core_clk, bus_clk, periph_clk, bus_out, bus_oen, clk_en, xsel, pin, half, por, mrst, irq;
    logic [7:0] mod_en;
    logic [2:0] mult;
    logic [15:0] rv;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    cpg_row_s rows [8] = '{'{3'h0, 1'b0, 16'h0e1a}, '{3'h1, 1'b0, 16'h0e23}, '{3'h2, 1'b0, 16'h0e13},
        '{3'h3, 1'b0, 16'h0e13}, '{3'h4, 1'b0, 16'h0e0a}, '{3'h5, 1'b0, 16'h0e0a},
        '{3'h2, 1'b1, 16'h0e13}, '{3'h6, 1'b0, 16'h0e1a}};

    cpg_clock_generator #(.STAB_CYC(STAB), .WDT_PRE_W(12)) i_cpg_clock_generator (
        .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_mode_select_bit0(mode[0]), .i_mode_select_bit1(mode[1]),
        .i_mode_select_bit2(mode[2]), .i_crystal_select(xsel), .i_wide_variant(wide), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_wake(i_wake),
        .o_core_clk(core_clk), .o_bus_clk(bus_clk), .o_periph_clk(periph_clk), .o_bus_clock_out(bus_out),
        .o_bus_clock_out_oen(bus_oen), .o_clock_enable(clk_en), .o_module_clk_en(mod_en), .o_mult(mult),
        .o_half_div_on(half), .o_poweron_rst_req(por), .o_manual_rst_req(mrst), .o_irq(irq));
    cpg_ext_board i_cpg_ext_board (.i_bus_clock_out(bus_out), .i_bus_clock_out_oen(bus_oen),
        .o_crystal_select(xsel), .o_pin_level(pin));

    // ----------------------------------------------------------------
    // clock, timeout and helpers
    // ----------------------------------------------------------------
    always #4 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        @(posedge i_ref_clk);
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [15:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_ref_clk);
    endtask : rd
    task automatic do_reset();
        i_rstn <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
    endtask : do_reset
    task automatic wait_hi(ref logic s, input int lim);
        for (int n = 0; n < lim && s !== 1'b1; n++) begin
            @(posedge i_ref_clk);
            #1;
        end
    endtask : wait_hi
    function automatic logic pick(input int k);
        return k == 0 ? core_clk : (k == 1 ? bus_clk : periph_clk);
    endfunction : pick
    task automatic half_len(input int k, output logic [15:0] n);
        n = 16'h0;
        while (pick(k) !== 1'b0) @(posedge i_ref_clk) #1;
        while (pick(k) !== 1'b1) @(posedge i_ref_clk) #1;
        while (pick(k) === 1'b1 && n < 16'h0028) begin
            @(posedge i_ref_clk) #1;
            n++;
        end
    endtask : half_len
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        foreach (rows[r]) begin
            mode <= rows[r].mode;
            wide <= rows[r].wide;
            do_reset();
            rd(CPG_FRQ_ADDR, rv);
            check(rv, rows[r].frq);
            rd(CPG_FRQ_ADDR_ALT, rv);
            check(rv, rows[r].frq);
            check({13'h0, mult}, 16'h0006);
            check({15'h0, clk_en}, 16'h0001);
            check({15'h0, half}, 16'h0000);
            check({8'h0, mod_en}, 16'h00ff);
            $display("power-on row %0d done", r);
        end
        wr(CPG_FRQ_ADDR, 16'h0e8d);
        repeat (STAB + 4) @(posedge i_ref_clk);
        half_len(0, rv);
        check(rv, 16'h0003);
        half_len(1, rv);
        check(rv, 16'h0002);
        half_len(2, rv);
        check(rv, 16'h0008);
        @(posedge i_ref_clk);
        wr(CPG_FRQ_ADDR_ALT, 16'hf21a);
        rd(CPG_STATE_ADDR, rv);
        check(rv & 16'h0003, 16'h0001);
        check({15'h0, clk_en}, 16'h0000);
        repeat (STAB) @(posedge i_ref_clk);
        rd(CPG_FRQ_ADDR, rv);
        check(rv, 16'h021a);
        check({13'h0, mult}, 16'h0001);
        check({14'h0, bus_oen, pin}, 16'h0003);
        check({15'h0, half}, 16'h0001);
        rd(CPG_IRQ_STAT_ADDR, rv);
        check(rv & 16'h0002, 16'h0002);
        wr(CPG_FRQ_ADDR, 16'h0e1a);
        repeat (STAB + 2) @(posedge i_ref_clk);
        $display("frequency control test done");
        wr(CPG_STB_ADDR, 16'h30a5);
        #1 check({8'h0, mod_en}, 16'h005a);
        check({15'h0, clk_en}, 16'h0000);
        repeat (6) @(posedge i_ref_clk) #1 check({15'h0, bus_out}, 16'h0001);
        wr(CPG_STB_ADDR, 16'h8000);
        rd(CPG_STATE_ADDR, rv);
        check(rv & 16'h0003, 16'h0002);
        i_wake <= 1'b1;
        @(posedge i_ref_clk);
        i_wake <= 1'b0;
        @(posedge i_ref_clk);
        rd(CPG_STATE_ADDR, rv);
        check(rv & 16'h0003, 16'h0000);
        wr(CPG_STB_ADDR, 16'h4000);
        i_wake <= 1'b1;
        @(posedge i_ref_clk);
        i_wake <= 1'b0;
        rd(CPG_STATE_ADDR, rv);
        check(rv & 16'h0003, 16'h0001);
        repeat (STAB) @(posedge i_ref_clk);
        rd(CPG_STATE_ADDR, rv);
        check(rv & 16'h0003, 16'h0000);
        $display("power-down test done");
        rd(32'hffc000f0, rv);
        check(rv, 16'h0000);
        wr(CPG_IRQ_STAT_ADDR, 16'h0007);
        wr(CPG_IRQ_MASK_ADDR, 16'h0001);
        wr(CPG_WDT_ADDR, 16'h00c0);
        #1 check({15'h0, irq}, 16'h0000);
        wait_hi(irq, 20000);
        rd(CPG_IRQ_STAT_ADDR, rv);
        check(rv & 16'h0001, 16'h0001);
        check({14'h0, por, mrst}, 16'h0000);
        wr(CPG_IRQ_MASK_ADDR, 16'h0000);
        #1 check({15'h0, irq}, 16'h0000);
        wr(CPG_IRQ_STAT_ADDR, 16'h0001);
        wr(CPG_IRQ_MASK_ADDR, 16'h0001);
        #1 check({15'h0, irq}, 16'h0000);
        wr(CPG_WDT_ADDR, 16'h00a0);
        wait_hi(mrst, 20000);
        check({14'h0, por, mrst}, 16'h0001);
        @(posedge i_ref_clk);
        wr(CPG_IRQ_STAT_ADDR, 16'h0007);
        wr(CPG_WDT_ADDR, 16'h0081);
        repeat (12000) @(posedge i_ref_clk);
        rd(CPG_IRQ_STAT_ADDR, rv);
        check(rv & 16'h0004, 16'h0000);
        wait_hi(por, 6000);
        check({14'h0, por, mrst}, 16'h0002);
        @(posedge i_ref_clk);
        wr(CPG_WDT_ADDR, 16'h0000);
        $display("watchdog test done");
        final_report();
    end
endmodule : cpg_clock_generator_test
